// >>> hw/rsc_core.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_core #(
    parameter int PM_WORDS = rsc_pkg::PM_WORDS_DEF,
    parameter int PCW = $clog2(PM_WORDS),
    parameter int RF_DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    output logic [PCW-1:0] o_pmem_addr,
    input wire logic [rsc_pkg::IW-1:0] i_pmem_data,
    output logic [rsc_pkg::DW-1:0] o_w,
    output logic [rsc_pkg::DW-1:0] o_status,
    output logic [rsc_pkg::DW-1:0] o_fsr
);
    import rsc_pkg::*;

    typedef struct packed {
        rsc_state_t st;
        logic [PCW-1:0] pc;
        logic [PCW-1:0] stk0;
        logic [PCW-1:0] stk1;
        logic [11:0] ir;
        logic [7:0] w;
        logic [7:0] stat;
        logic [7:0] fsr;
    } rsc_core_st_t;

    localparam logic [PCW-1:0] RESET_VEC = '1;

    rsc_core_st_t s_r, s_nxt;
    rsc_alu_in_t ai;
    rsc_alu_out_t ao;
    rsc_rf_wr_t rfw;
    logic [11:0] ins;
    logic [4:0] ea;
    logic [7:0] fval;
    logic [7:0] rf_rdata;
    logic [10:0] tgt;
    logic wr_f, wr_w, fc, fdc, fz;
    logic taken, skip;

    rsc_alu u_alu (
        .i_in(ai),
        .o_out(ao)
    );

    rsc_regfile #(.DEPTH(RF_DEPTH)) u_rf (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_raddr(ea),
        .o_rdata(rf_rdata),
        .i_wr(rfw)
    );

    assign ins = s_r.ir;

    // operand address and file read
    always_comb begin
        ea = (ins[4:0] == A_INDF) ? s_r.fsr[4:0] : ins[4:0];
        // special registers and pc in data space
        unique case (ea)
            A_INDF: fval = 8'h00;
            A_PCL: fval = s_r.pc[7:0];
            A_STAT: fval = s_r.stat;
            A_FSR: fval = s_r.fsr;
            default: fval = rf_rdata;
        endcase
    end

    // decode, execute and fetch
    always_comb begin
        s_nxt = s_r;
        // fetch next word while executing ir
        s_nxt.pc = PCW'(s_r.pc + 1'b1);
        s_nxt.ir = i_pmem_data;
        s_nxt.st = ST_RUN;
        ai.op = ALU_PASSA;
        ai.a = fval;
        ai.w = s_r.w;
        ai.cin = s_r.stat[SB_C];
        ai.bitn = ins[7:5];
        wr_f = 1'b0;
        wr_w = 1'b0;
        fc = 1'b0;
        fdc = 1'b0;
        fz = 1'b0;
        taken = 1'b0;
        skip = 1'b0;
        tgt = 11'h000;
        rfw.we = 1'b0;
        rfw.addr = ea;
        rfw.data = 8'h00;
        casez (ins)
            12'b0000_001?_????: begin
                ai.op = ALU_PASSW;
                wr_f = 1'b1;
            end
            12'b0000_0100_0000: begin
                ai.op = ALU_CLR;
                wr_w = 1'b1;
                fz = 1'b1;
            end
            12'b0000_011?_????: begin
                ai.op = ALU_CLR;
                wr_f = 1'b1;
                fz = 1'b1;
            end
            12'b0000_1???_????, 12'b0001_????_????,
            12'b0010_????_????, 12'b0011_????_????: begin
                // file operand, result to file or acc
                wr_f = ins[5];
                wr_w = !ins[5];
                fz = 1'b1;
                unique case (ins[9:6])
                    4'h2: begin
                        ai.op = ALU_SUB;
                        fc = 1'b1;
                        fdc = 1'b1;
                    end
                    4'h3: ai.op = ALU_DEC;
                    4'h4: ai.op = ALU_IOR;
                    4'h5: ai.op = ALU_AND;
                    4'h6: ai.op = ALU_XOR;
                    4'h7: begin
                        ai.op = ALU_ADD;
                        fc = 1'b1;
                        fdc = 1'b1;
                    end
                    4'h8: ai.op = ALU_PASSA;
                    4'h9: ai.op = ALU_COM;
                    4'hA: ai.op = ALU_INC;
                    4'hB: begin
                        ai.op = ALU_DEC;
                        fz = 1'b0;
                        skip = ao.z;
                    end
                    4'hC: begin
                        ai.op = ALU_RRF;
                        fz = 1'b0;
                        fc = 1'b1;
                    end
                    4'hD: begin
                        ai.op = ALU_RLF;
                        fz = 1'b0;
                        fc = 1'b1;
                    end
                    4'hE: begin
                        ai.op = ALU_SWAP;
                        fz = 1'b0;
                    end
                    4'hF: begin
                        ai.op = ALU_INC;
                        fz = 1'b0;
                        skip = ao.z;
                    end
                    default: begin
                        wr_f = 1'b0;
                        wr_w = 1'b0;
                        fz = 1'b0;
                    end
                endcase
            end
            12'b0100_????_????: begin
                ai.op = ALU_BCLR;
                wr_f = 1'b1;
            end
            12'b0101_????_????: begin
                ai.op = ALU_BSET;
                wr_f = 1'b1;
            end
            12'b0110_????_????: skip = !ao.btst;
            12'b0111_????_????: skip = ao.btst;
            12'b1000_????_????: begin
                // return with literal
                s_nxt.w = ins[7:0];
                s_nxt.pc = s_r.stk0;
                s_nxt.stk0 = s_r.stk1;
                taken = 1'b1;
            end
            12'b1001_????_????: begin
                tgt = {s_r.stat[SB_PA+1:SB_PA], 1'b0, ins[7:0]};
                s_nxt.pc = tgt[PCW-1:0];
                s_nxt.stk1 = s_r.stk0;
                s_nxt.stk0 = PCW'(s_r.pc);
                taken = 1'b1;
            end
            12'b101?_????_????: begin
                tgt = {s_r.stat[SB_PA+1:SB_PA], ins[8:0]};
                s_nxt.pc = tgt[PCW-1:0];
                taken = 1'b1;
            end
            12'b11??_????_????: begin
                // literal operand
                ai.a = ins[7:0];
                wr_w = 1'b1;
                fz = (ins[9:8] != 2'b00);
                unique case (ins[9:8])
                    2'b00: ai.op = ALU_PASSA;
                    2'b01: ai.op = ALU_IOR;
                    2'b10: ai.op = ALU_AND;
                    2'b11: ai.op = ALU_XOR;
                endcase
            end
            default: ;
        endcase
        // acc written by result path, or by the literal on return
        if (wr_w) begin
            s_nxt.w = ao.res;
        end
        if (wr_f) begin
            unique case (ea)
                A_INDF: ;
                A_PCL: begin
                    tgt = {s_r.stat[SB_PA+1:SB_PA], 1'b0, ao.res};
                    s_nxt.pc = tgt[PCW-1:0];
                    taken = 1'b1;
                end
                A_STAT: s_nxt.stat = ao.res;
                A_FSR: s_nxt.fsr = ao.res;
                default: begin
                    rfw.we = 1'b1;
                    rfw.data = ao.res;
                end
            endcase
        end
        if (fc) begin
            s_nxt.stat[SB_C] = ao.c;
        end
        if (fdc) begin
            s_nxt.stat[SB_DC] = ao.dc;
        end
        if (fz) begin
            s_nxt.stat[SB_Z] = ao.z;
        end
        // discard prefetch on branch or skip
        if (taken || skip) begin
            s_nxt.ir = INS_NOP;
            s_nxt.st = ST_FLUSH;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s_r <= '{st: ST_FLUSH, pc: RESET_VEC, stk0: '0, stk1: '0,
                     ir: INS_NOP, w: W_RST, stat: STAT_RST,
                     fsr: FSR_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_pmem_addr = s_r.pc;
    assign o_w = s_r.w;
    assign o_status = s_r.stat;
    assign o_fsr = s_r.fsr;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_fetch_step: assert property (!taken |=>
        o_pmem_addr == PCW'($past(o_pmem_addr) + 1'b1))
        else $error("fetch address did not advance by one");
    a_pipe_load: assert property (!taken && !skip |=>
        ins == $past(i_pmem_data))
        else $error("prefetched word not loaded");
    a_single_cyc: assert property (s_r.st == ST_RUN && !taken &&
        !skip |=> s_r.st == ST_RUN)
        else $error("pipeline stalled on a plain instruction");
    // two cycles for a taken branch
    a_branch_flush: assert property (taken |=>
        ins == INS_NOP ##1 s_r.st == ST_RUN)
        else $error("branch did not flush exactly one slot");
    a_acc_nomap: assert property (wr_f && !wr_w && !taken |=>
        o_w == $past(o_w))
        else $error("file write changed accumulator");
    a_add_carry: assert property (ai.op == ALU_ADD && fc |=>
        o_status[SB_C] == $past(({1'b0, ai.a} + {1'b0, ai.w}) > 9'h0FF))
        else $error("add carry wrong");
    a_sub_borrow: assert property (ai.op == ALU_SUB && fc |=>
        o_status[SB_C] == $past(ai.a >= ai.w) &&
        o_status[SB_DC] == $past(ai.a[3:0] >= ai.w[3:0]))
        else $error("subtract borrow flags wrong");
    a_zero_flag: assert property (fz && !(wr_f && ea == A_STAT) |=>
        o_status[SB_Z] == ($past(ao.res) == 8'h00))
        else $error("zero flag wrong");
    // indirect write lands where the pointer says
    a_indirect: assert property (wr_f && ins[4:0] == A_INDF &&
        s_r.fsr[4:0] > A_FSR |-> rfw.we && rfw.addr == s_r.fsr[4:0] &&
        rfw.data == ao.res)
        else $error("indirect write missed the pointed register");
    a_lit_load: assert property (ins[11:8] == 4'hC |=>
        o_w == $past(ins[7:0]))
        else $error("literal load failed");

    c_branch: cover property (taken ##2 s_r.st == ST_RUN);
    c_sub: cover property (ai.op == ALU_SUB && fc);
    c_indirect: cover property (ins[4:0] == A_INDF && wr_f);
    c_skip: cover property (skip);
endmodule // rsc_core
`default_nettype wire

// >>> hw/rsc_pkg.sv
// Notes on behaviour
// - each instruction is fetched as one 12-bit word in one cycle.
// - the next fetch overlaps execution of the current instruction.
// - all 29 instructions, nop included, take one cycle except flow changes.
// - program space is 512, 1K or 2K words; the pc width follows it.
// - program memory is on-chip only, with no external fetch path.
// - the pc low byte and all special registers sit in data space.
// - any file location is reached directly or through the pointer.
// - an 8-bit alu adds, subtracts, shifts and does logic.
// - arithmetic is two's complement.
// - two-operand ops use the accumulator and a file or a literal.
// - single-operand ops work on the accumulator or a file register.
// - the 8-bit accumulator has no data-space address.
// - the alu updates carry, nibble carry and zero per instruction.
// - in subtraction carry and nibble carry are inverted borrows.
// - a data access and a fetch happen in the same cycle.
package rsc_pkg;
    localparam int IW = 12;
    localparam int DW = 8;
    localparam int FAW = 5;
    localparam int PM_WORDS_DEF = 512;
    // special file addresses
    localparam logic [4:0] A_INDF = 5'h00;
    localparam logic [4:0] A_PCL = 5'h02;
    localparam logic [4:0] A_STAT = 5'h03;
    localparam logic [4:0] A_FSR = 5'h04;
    // status field positions
    localparam int SB_C = 0;
    localparam int SB_DC = 1;
    localparam int SB_Z = 2;
    localparam int SB_PA = 5;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] FSR_RST = 8'h00;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [11:0] INS_NOP = 12'h000;

    typedef enum logic [3:0] {
        ALU_PASSA, ALU_PASSW, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND,
        ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RRF,
        ALU_RLF, ALU_SWAP, ALU_BCLR, ALU_BSET
    } rsc_aluop_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_FLUSH = 2'b10
    } rsc_state_t;

    typedef struct packed {
        rsc_aluop_t op;
        logic [7:0] a;
        logic [7:0] w;
        logic cin;
        logic [2:0] bitn;
    } rsc_alu_in_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic dc;
        logic z;
        logic btst;
    } rsc_alu_out_t;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } rsc_rf_wr_t;
endpackage

// >>> hw/rsc_alu.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_alu (
    input wire rsc_pkg::rsc_alu_in_t i_in,
    output rsc_pkg::rsc_alu_out_t o_out
);
    import rsc_pkg::*;
    logic [8:0] sum;
    logic [4:0] nib;

    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        o_out.res = 8'h00;
        o_out.c = i_in.cin;
        o_out.dc = 1'b0;
        unique case (i_in.op)
            ALU_PASSA: o_out.res = i_in.a;
            ALU_PASSW: o_out.res = i_in.w;
            ALU_CLR: o_out.res = 8'h00;
            ALU_ADD: begin
                sum = {1'b0, i_in.a} + {1'b0, i_in.w};
                nib = {1'b0, i_in.a[3:0]} + {1'b0, i_in.w[3:0]};
            end
            ALU_SUB: begin
                sum = {1'b0, i_in.a} + {1'b0, ~i_in.w} + 9'h001;
                nib = {1'b0, i_in.a[3:0]} + {1'b0, ~i_in.w[3:0]} + 5'h01;
            end
            ALU_AND: o_out.res = i_in.a & i_in.w;
            ALU_IOR: o_out.res = i_in.a | i_in.w;
            ALU_XOR: o_out.res = i_in.a ^ i_in.w;
            ALU_COM: o_out.res = ~i_in.a;
            ALU_INC: o_out.res = i_in.a + 8'h01;
            ALU_DEC: o_out.res = i_in.a - 8'h01;
            ALU_RRF: begin
                o_out.res = {i_in.cin, i_in.a[7:1]};
                o_out.c = i_in.a[0];
            end
            ALU_RLF: begin
                o_out.res = {i_in.a[6:0], i_in.cin};
                o_out.c = i_in.a[7];
            end
            ALU_SWAP: o_out.res = {i_in.a[3:0], i_in.a[7:4]};
            ALU_BCLR: o_out.res = i_in.a & ~(8'h01 << i_in.bitn);
            ALU_BSET: o_out.res = i_in.a | (8'h01 << i_in.bitn);
        endcase
        if (i_in.op == ALU_ADD || i_in.op == ALU_SUB) begin
            o_out.res = sum[7:0];
            o_out.c = sum[8];
            o_out.dc = nib[4];
        end
        o_out.z = (o_out.res == 8'h00);
        o_out.btst = i_in.a[i_in.bitn];
    end
endmodule // rsc_alu
`default_nettype wire

// >>> hw/rsc_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_regfile #(
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [rsc_pkg::FAW-1:0] i_raddr,
    output logic [rsc_pkg::DW-1:0] o_rdata,
    input wire rsc_pkg::rsc_rf_wr_t i_wr
);
    import rsc_pkg::*;
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } rsc_rf_st_t;
    rsc_rf_st_t s_r, s_nxt;

    // asynchronous read; data path separate from program bus
    assign o_rdata = (int'(i_raddr) < DEPTH) ? s_r.mem[i_raddr] : 8'h00;

    // write port
    always_comb begin
        s_nxt = s_r;
        for (int k = 0; k < DEPTH; k++) begin
            if (i_wr.we && int'(i_wr.addr) == k) begin
                s_nxt.mem[k] = i_wr.data;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // rsc_regfile
`default_nettype wire

// >>> tb/rsc_pmem_model.sv
`timescale 1ns/100ps
`default_nettype none
// on-chip program store answering combinationally, like a rom
module rsc_pmem_model #(
    parameter int PCW = 9
) (
    input wire logic [PCW-1:0] i_addr,
    output logic [rsc_pkg::IW-1:0] o_data
);
    logic [rsc_pkg::IW-1:0] mem [2**PCW];

    assign o_data = mem[i_addr]; // unknown address gives unknown word
endmodule // rsc_pmem_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rsc_pkg::*;
    localparam int PCW = 9;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [PCW-1:0] pmem_addr;
    logic [IW-1:0] pmem_data;
    logic [DW-1:0] w;
    logic [DW-1:0] status;
    logic [DW-1:0] fsr;
    int miscompares = 0;
    int checks = 0;

    // free running 100 MHz clock
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    rsc_core #(.PM_WORDS(512), .PCW(PCW), .RF_DEPTH(32)) u_rsc_core (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .o_pmem_addr(pmem_addr),
        .i_pmem_data(pmem_data),
        .o_w(w),
        .o_status(status),
        .o_fsr(fsr)
    );

    rsc_pmem_model #(.PCW(PCW)) u_rsc_pmem_model (
        .i_addr(pmem_addr),
        .o_data(pmem_data)
    );

    // compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic results();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // advance n edges, then sample settled outputs
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // reset for 6 cycles while loading a program, then release
    task automatic restart(input logic [11:0] prog [$]);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        for (int i = 0; i < 2**PCW; i++) u_rsc_pmem_model.mem[i] <= INS_NOP;
        foreach (prog[i]) u_rsc_pmem_model.mem[i] <= prog[i];
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1;
    endtask

    // load file 0x10, load acc, run one op into acc, check result and flags
    task automatic arith(input logic [11:0] op, input logic [7:0] fv, wv,
                         input logic [7:0] ew, input logic [2:0] ef);
        restart('{12'hC00 | fv, 12'h030, 12'hC00 | wv, op | 12'h010});
        step(6);
        check(w, ew);
        check(status[2:0], ef);
    endtask

    task automatic t_reset();
        restart('{12'hC5A});
        check(pmem_addr, 12'h1FF);
        check(w, W_RST);
        check(status, STAT_RST);
        check(fsr, FSR_RST);
        for (int i = 0; i < 8; i++) begin
            step(1);
            check(pmem_addr, 12'(i));
        end
        check(w, 8'h5A);
    endtask

    task automatic t_add();
        arith(12'h1C0, 8'h0F, 8'h01, 8'h10, 3'b010);
        arith(12'h1C0, 8'hFF, 8'h01, 8'h00, 3'b111);
        arith(12'h1C0, 8'h88, 8'h88, 8'h10, 3'b011);
    endtask

    task automatic t_sub();
        arith(12'h080, 8'h05, 8'h03, 8'h02, 3'b011);
        arith(12'h080, 8'h03, 8'h05, 8'hFE, 3'b000);
        arith(12'h080, 8'h10, 8'h01, 8'h0F, 3'b001);
        arith(12'h080, 8'h05, 8'h05, 8'h00, 3'b111);
    endtask

    task automatic t_logic();
        arith(12'h140, 8'hF0, 8'h0F, 8'h00, 3'b100);
        arith(12'h180, 8'hFF, 8'h0F, 8'hF0, 3'b000);
        arith(12'h100, 8'h00, 8'h00, 8'h00, 3'b100);
        arith(12'h240, 8'h55, 8'h00, 8'hAA, 3'b000);
        arith(12'h280, 8'hFF, 8'h00, 8'h00, 3'b100);
        arith(12'h0C0, 8'h01, 8'h00, 8'h00, 3'b100);
        arith(12'h300, 8'h01, 8'h00, 8'h00, 3'b001);
        arith(12'h340, 8'h80, 8'h00, 8'h00, 3'b001);
        arith(12'h380, 8'hA5, 8'h00, 8'h5A, 3'b000);
        arith(12'h2C0, 8'h01, 8'h33, 8'h00, 3'b000);
        arith(12'h060, 8'h55, 8'h77, 8'h77, 3'b100);
        arith(12'hD00, 8'h00, 8'h01, 8'h11, 3'b000);
        arith(12'hE00, 8'h00, 8'h3F, 8'h10, 3'b000);
        arith(12'hF00, 8'h00, 8'h10, 8'h00, 3'b100);
    endtask

    // call and return each discard one prefetched word
    task automatic t_call();
        restart('{12'h904, 12'hC3C, INS_NOP, INS_NOP, 12'h8A5});
        step(3);
        check(pmem_addr, 12'h004);
        step(2);
        check(pmem_addr, 12'h001);
        check(w, 8'hA5);
        step(2);
        check(w, 8'h3C);
    endtask

    task automatic t_branch();
        logic [11:0] exp_a [4] = '{12'h000, 12'h001, 12'h005, 12'h006};
        restart('{12'hA05, 12'hCAA, INS_NOP, INS_NOP, INS_NOP, 12'hC55});
        foreach (exp_a[i]) begin
            step(1);
            check(pmem_addr, exp_a[i]);
        end
        check(w, 8'h00);
        step(1);
        check(w, 8'h55);
    endtask

    // bit set then skip over one word
    task automatic t_skip();
        restart('{12'hC00, 12'h030, 12'h570, 12'h770, 12'hC77, 12'h210});
        step(7);
        check(w, 8'h00);
        step(1);
        check(w, 8'h08);
    endtask

    // pointer access, pc and status in data space
    task automatic t_indirect();
        restart('{12'hC11, 12'h024, 12'hC3C, 12'h020, 12'hC00, 12'h211,
                  12'h202, 12'hC01, 12'h023});
        step(8);
        check(w, 8'h3C);
        check(fsr, 8'h11);
        step(1);
        check(w, 8'h07);
        step(2);
        check(status[2:0], 3'b001);
    endtask

    // main sequence
    initial begin
        t_reset();
        t_add();
        t_sub();
        t_logic();
        t_branch();
        t_call();
        t_skip();
        t_indirect();
        results();
    end

    // run limit in case the sequence hangs
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule // tb_top
`default_nettype wire
